// [dicd_decoder.sv]
// Purpose: turns five programmable digital terminals into drive commands
// Assumes: terminal levels synchronous to clock_in; settings written while quiet
// Notes:   a refused code leaves the old code in place and is flagged
`timescale 1ns/1ns
`default_nettype none

// What this block does
// (R1) each terminal has its own code selecting its command
// (R2) reset defaults: start, reversing, clear-and-freewheel, inch, none
// (R3) codes 26/27 only on 18/19, 30 only on 33, 34-36 only 29/33
// (R4) pulse codes on terminal 29 refused while output pin in pulse mode
// (R5) code 0 terminals ignored entirely
// (R6) reset code clears alarm on rising edge, trip-locked alarms stay
// (R7) coast-low terminal low disables output stage at once
// (R8) clear-and-freewheel low coasts; falling edge resets alarm
// (R9) quick-stop low ramps down with quick-stop ramp
// (R10) dc halt low brakes only if time and voltage settings nonzero
// (R11) stop-low low ramps to standstill on selected ramp
// (R12) start is a level: high runs, low stops
// (R13) latched start needs 14 ms pulse, latches unless stopped
// (R14) reversing flips direction while high, never starts, off in closed loop
// (R15) start-reverse runs and reverses; off in closed loop; no other start
// (R16) clockwise/anticlockwise start run limited to one direction; in closed loop both still run but limits and reverse stay off
// (R17) inch forces jog frequency regardless of start, unless coast/quick/dc
// (R18) freeze reference holds, changed only by up/down, kept across stops
// (R19) freeze output holds frequency, changed only by up/down
// (R20) frozen output stops only by coast, quick-stop or dc from input
// (R21) up/down pulses 14 ms high, 14 ms low, one step each; the code steps only while a freeze terminal is high
// (R22) inputs synchronised, edges found from synchronised samples
module dicd_decoder
  import dicd_pkg::*;
#(
  parameter int PULSE_CYC = PULSE_MIN_CYC
) (
  // clock and reset
  input  wire logic                 clock_in,
  input  wire logic                 rst_b_in,
  // terminals and settings
  input  wire logic [NUM_TERM-1:0]  term_in,
  input  wire logic                 code_wr_in,
  input  wire logic [2:0]           code_sel_in,
  input  wire logic [CODE_W-1:0]    code_val_in,
  input  wire logic                 out_pin_pulse_mode_in,
  input  wire logic                 closed_loop_in,
  input  wire logic                 dc_time_nonzero_in,
  input  wire logic                 dc_volt_nonzero_in,
  input  wire logic                 alarm_trip_locked_in,
  // configuration readback
  output logic [NUM_TERM*CODE_W-1:0] code_out,
  output logic                       code_refused_out,
  // drive commands
  output logic                       alarm_reset_out,
  output logic                       coast_out,
  output logic                       quick_stop_out,
  output logic                       dc_brake_out,
  output logic                       ramp_stop_out,
  output logic                       run_out,
  output logic                       reverse_out,
  output logic                       dir_limit_cw_out,
  output logic                       dir_limit_ccw_out,
  output logic                       inch_speed_override_out,
  output logic                       freeze_ref_out,
  output logic                       freeze_out_out,
  output logic                       step_up_out,
  output logic                       step_down_out
);

  // stored codes, one per terminal, in term_in bit order
  logic [CODE_W-1:0]   code_reg [NUM_TERM];
  // two sampling stages, one history stage for edges, and a fill marker
  logic [NUM_TERM-1:0] sync1_reg;
  logic [NUM_TERM-1:0] sync2_reg;
  logic [NUM_TERM-1:0] prev_reg;
  logic [2:0]          fill_reg;
  // latched start state
  logic                latch_run_reg;
  logic [PCNT_W-1:0]   hi_cnt_reg;
  logic                latch_ok_reg;
  // up/down qualifiers: high time, low time, armed after a full gap
  logic [PCNT_W-1:0]   up_hi_reg;
  logic [PCNT_W-1:0]   up_lo_reg;
  logic                up_armed_reg;
  logic [PCNT_W-1:0]   dn_hi_reg;
  logic [PCNT_W-1:0]   dn_lo_reg;
  logic                dn_armed_reg;

  // the limit must fit the counter width; the default of 14 ms needs twenty bits
  // counters stop at the limit, so a long hold never wraps into a second step
  localparam logic [PCNT_W-1:0] PULSE_LIM = PCNT_W'(PULSE_CYC);

  // legality of a code on a terminal index
  function automatic logic code_legal(input logic [2:0] t, input logic [5:0] c,
                                      input logic pulse_mode);
    logic ok;
    // codes without a terminal limit are legal everywhere
    ok = 1'b1;
    if (c == FN_ACC_HALT || c == FN_ACC_STARTSTP)
      ok = (t <= 3'd1);                                          // R3
    else if (c == FN_PULSE_IN)
      ok = (t == 3'd4);                                          // R3
    else if (c >= FN_ENC_REF && c <= FN_ENC_LAST)
      ok = (t == 3'd3 || t == 3'd4);                             // R3
    else if (c == FN_PULSE_REF || c == FN_PULSE_FB)
      ok = (t == 3'd4) || (t == 3'd3 && !pulse_mode);            // R3 R4
    else if (c == 6'h12 || c == 6'h19 || c > FN_ENC_LAST)
      ok = 1'b0;                                                 // unassigned codes
    return ok;
  endfunction

  // function settings; refused writes leave the old code
  // an index above the last terminal is ignored and leaves the flag alone
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < NUM_TERM; i++) begin
        code_reg[i] <= CODE_RESET_VAL[i*CODE_W +: CODE_W];        // R2
      end
      code_refused_out <= 1'b0;
    end else if (code_wr_in && code_sel_in < 3'(NUM_TERM)) begin
      if (code_legal(code_sel_in, code_val_in, out_pin_pulse_mode_in)) begin
        code_reg[code_sel_in] <= code_val_in;                     // R1
        code_refused_out <= 1'b0;
      end else begin
        code_refused_out <= 1'b1;                                 // R4
      end
    end
  end

  // synchroniser and edge history
  // presets are not pin levels, so decoding waits until the fill marker is full
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      prev_reg  <= '1;
      fill_reg  <= '0;
    end else begin
      sync1_reg <= term_in;                                       // R22
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
      fill_reg  <= {fill_reg[1:0], 1'b1};                         // R22
    end
  end

  // per-function decode over all terminals
  logic any_reset_rise, any_clear_fall, any_coast, any_qstop, any_dc, any_stop;
  logic any_start, any_latch, any_rev, any_srev, any_cw, any_ccw, any_inch;
  logic any_fref, any_fout, any_up, any_dn;
  always_comb begin
    {any_reset_rise, any_clear_fall, any_coast, any_qstop, any_dc, any_stop} = '0;
    {any_start, any_latch, any_rev, any_srev, any_cw, any_ccw, any_inch} = '0;
    {any_fref, any_fout, any_up, any_dn} = '0;
    for (int i = 0; i < NUM_TERM; i++) begin
      // code 0 matches no case and contributes nothing; until the
      // pipeline holds real levels every terminal reads as unused
      unique case (fill_reg[2] ? code_reg[i] : FN_NONE)           // R5 R22
        FN_RESET:       any_reset_rise |= sync2_reg[i] & ~prev_reg[i];  // R6
        FN_COAST_LOW:   any_coast |= ~sync2_reg[i];               // R7
        FN_CLEAR_FREE: begin
          any_coast      |= ~sync2_reg[i];                        // R8
          any_clear_fall |= ~sync2_reg[i] & prev_reg[i];          // R8
        end
        FN_QSTOP_LOW:   any_qstop |= ~sync2_reg[i];               // R9
        FN_DCINJ_LOW:   any_dc |= ~sync2_reg[i];                  // R10
        FN_STOP_LOW,
        FN_ACC_HALT:    any_stop |= ~sync2_reg[i];                // R11
        FN_START:       any_start |= sync2_reg[i];                // R12
        FN_LATCH_START: any_latch |= sync2_reg[i];
        FN_REVERSE:     any_rev |= sync2_reg[i];                  // R14
        FN_START_REV:   any_srev |= sync2_reg[i];                 // R15
        FN_START_CW:    any_cw |= sync2_reg[i];                   // R16
        FN_START_CCW:   any_ccw |= sync2_reg[i];                  // R16
        FN_INCH:        any_inch |= sync2_reg[i];
        FN_FREEZE_REF:  any_fref |= sync2_reg[i];
        FN_FREEZE_OUT:  any_fout |= sync2_reg[i];
        FN_SPEED_UP:    any_up |= sync2_reg[i];
        FN_SPEED_DOWN:  any_dn |= sync2_reg[i];
        default: ;
      endcase
    end
  end

  // coast, quick stop and live dc braking outrank every start and the inch speed
  logic dc_active;
  logic hard_stop;
  assign dc_active = any_dc & dc_time_nonzero_in & dc_volt_nonzero_in;  // R10
  assign hard_stop = any_coast | any_qstop | dc_active;

  // latched start: pulse must stand 14 ms; a stop clears it
  // the latch outlives the pulse; only a stop ends it
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hi_cnt_reg    <= '0;
      latch_ok_reg  <= 1'b0;
      latch_run_reg <= 1'b0;
    end else begin
      if (!any_latch) begin
        hi_cnt_reg   <= '0;
        latch_ok_reg <= 1'b0;
      end else if (hi_cnt_reg < PULSE_LIM) begin
        hi_cnt_reg <= hi_cnt_reg + 1'b1;
      end else begin
        latch_ok_reg <= 1'b1;                                     // R13
      end
      if (any_stop || hard_stop)
        latch_run_reg <= 1'b0;                                    // R13
      else if (latch_ok_reg)
        latch_run_reg <= 1'b1;                                    // R13
    end
  end

  // up/down pulse qualifier: 14 ms high after 14 ms low gives one step while a freeze terminal is high
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      up_hi_reg <= '0;
      up_lo_reg <= '0;
      up_armed_reg <= 1'b0;
      dn_hi_reg <= '0;
      dn_lo_reg <= '0;
      dn_armed_reg <= 1'b0;
      step_up_out <= 1'b0;
      step_down_out <= 1'b0;
    end else begin
      step_up_out <= 1'b0;
      step_down_out <= 1'b0;
      // down wins when both are high, so up is blocked then
      if (any_up && !any_dn) begin
        up_lo_reg <= '0;
        if (up_hi_reg < PULSE_LIM)
          up_hi_reg <= up_hi_reg + 1'b1;
        else if (up_armed_reg && (any_fref || any_fout)) begin
          step_up_out  <= 1'b1;                                   // R21
          up_armed_reg <= 1'b0;
        end
      end else begin
        up_hi_reg <= '0;
        if (up_lo_reg < PULSE_LIM)
          up_lo_reg <= up_lo_reg + 1'b1;
        else
          up_armed_reg <= 1'b1;                                   // R21
      end
      if (any_dn) begin
        dn_lo_reg <= '0;
        if (dn_hi_reg < PULSE_LIM)
          dn_hi_reg <= dn_hi_reg + 1'b1;
        else if (dn_armed_reg && (any_fref || any_fout)) begin
          step_down_out <= 1'b1;                                  // R21
          dn_armed_reg  <= 1'b0;
        end
      end else begin
        dn_hi_reg <= '0;
        if (dn_lo_reg < PULSE_LIM)
          dn_lo_reg <= dn_lo_reg + 1'b1;
        else
          dn_armed_reg <= 1'b1;
      end
    end
  end

  // registered command outputs
  // every command leaves from a flip-flop; level commands three cycles after their terminal moves
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      alarm_reset_out <= 1'b0;
      coast_out <= 1'b0;
      quick_stop_out <= 1'b0;
      dc_brake_out <= 1'b0;
      ramp_stop_out <= 1'b0;
      run_out <= 1'b0;
      reverse_out <= 1'b0;
      dir_limit_cw_out <= 1'b0;
      dir_limit_ccw_out <= 1'b0;
      inch_speed_override_out <= 1'b0;
      freeze_ref_out <= 1'b0;
      freeze_out_out <= 1'b0;
      code_out <= CODE_RESET_VAL;
    end else begin
      // trip-locked alarms need a power cycle, never an input reset
      alarm_reset_out <= (any_reset_rise | any_clear_fall) & ~alarm_trip_locked_in; // R6 R8
      coast_out       <= any_coast;                               // R7
      quick_stop_out  <= any_qstop;                               // R9
      dc_brake_out    <= dc_active;                               // R10
      // frozen output ignores ramp stops and start loss
      ramp_stop_out   <= any_stop & ~any_fout;                    // R11 R20
      if (hard_stop)
        run_out <= 1'b0;                                          // R20
      else if (!any_fout)
        run_out <= (any_start | latch_run_reg | any_cw | any_ccw
                    | (any_srev & ~closed_loop_in)) & ~any_stop;  // R12 R15 R16
      reverse_out <= ~closed_loop_in & (any_rev | any_srev | any_ccw); // R14 R15
      dir_limit_cw_out  <= any_cw & ~closed_loop_in;              // R16
      dir_limit_ccw_out <= any_ccw & ~closed_loop_in;             // R16
      inch_speed_override_out <= any_inch & ~hard_stop;           // R17
      freeze_ref_out <= any_fref;                                 // R18
      freeze_out_out <= any_fout;                                 // R19
      // readback lags the stored code by one cycle
      for (int i = 0; i < NUM_TERM; i++) begin
        code_out[i*CODE_W +: CODE_W] <= code_reg[i];
      end
    end
  end

endmodule
`default_nettype wire

// [dicd_decoder_asserts.sv]
// Purpose: port-level checks for the input command decoder
// Assumes: one clock, async active-low reset
// Notes:   two sync stages plus output register give three cycles of lag
`timescale 1ns/1ns
`default_nettype none
module dicd_decoder_chk
  import dicd_pkg::*;
(
  // clock and reset
  input wire logic                       clock_in,
  input wire logic                       rst_b_in,
  // inputs
  input wire logic [NUM_TERM-1:0]        term_in,
  input wire logic                       code_wr_in,
  input wire logic [2:0]                 code_sel_in,
  input wire logic [CODE_W-1:0]          code_val_in,
  input wire logic                       out_pin_pulse_mode_in,
  input wire logic                       alarm_trip_locked_in,
  // outputs
  input wire logic [NUM_TERM*CODE_W-1:0] code_out,
  input wire logic                       code_refused_out,
  input wire logic                       alarm_reset_out,
  input wire logic                       coast_out,
  input wire logic                       quick_stop_out,
  input wire logic                       run_out,
  input wire logic                       reverse_out,
  input wire logic                       inch_speed_override_out,
  input wire logic                       step_up_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // readback moves only two edges after a write strobe
  chk_code_holds: assert property (!$past(code_wr_in, 2) |-> $stable(code_out))
    else $error("code changed without a write");
  // terminal restrictions on the settings
  chk_refuse_keeps: assert property (code_wr_in && code_sel_in == 3'h0 &&
    code_val_in == FN_PULSE_IN |=> code_refused_out && $stable(code_out))
    else $error("pulse input taken on first terminal");
  chk_accept_write: assert property (code_wr_in && code_sel_in == 3'h4 &&
    code_val_in == FN_PULSE_IN |=> !code_refused_out ##1 code_out[29:24] == FN_PULSE_IN)
    else $error("pulse input not taken on last terminal");
  chk_pulse_mode: assert property (code_wr_in && code_sel_in == 3'h3 &&
    code_val_in == FN_PULSE_REF && out_pin_pulse_mode_in |=> code_refused_out)
    else $error("pulse code taken while output pin pulses");
  // a coast-low terminal held low must coast within the pipeline lag
  chk_coast_low: assert property ((code_out[17:12] == FN_COAST_LOW && !term_in[2])[*3]
    |=> coast_out) else $error("coast missing");
  chk_trip_lock: assert property (alarm_trip_locked_in[*3] |=> !alarm_reset_out)
    else $error("reset of trip-locked alarm");
  chk_inch_block: assert property (coast_out || quick_stop_out |-> !inch_speed_override_out)
    else $error("inch during stop");
  chk_none_quiet: assert property ((code_out == 30'h0)[*4] |->
    !coast_out && !reverse_out && !inch_speed_override_out && !alarm_reset_out)
    else $error("command from unused terminal");
  chk_step_pulse: assert property (step_up_out |=> !step_up_out)
    else $error("step pulse too wide");
  // main scenarios reached
  cover property ($rose(run_out));
  cover property (alarm_reset_out);
  cover property (step_up_out);
endmodule
bind dicd_decoder dicd_decoder_chk i_dicd_decoder_chk (
  .clock_in(clock_in), .rst_b_in(rst_b_in), .term_in(term_in), .code_wr_in(code_wr_in),
  .code_sel_in(code_sel_in), .code_val_in(code_val_in),
  .out_pin_pulse_mode_in(out_pin_pulse_mode_in), .alarm_trip_locked_in(alarm_trip_locked_in),
  .code_out(code_out), .code_refused_out(code_refused_out), .alarm_reset_out(alarm_reset_out),
  .coast_out(coast_out), .quick_stop_out(quick_stop_out), .run_out(run_out),
  .reverse_out(reverse_out), .inch_speed_override_out(inch_speed_override_out),
  .step_up_out(step_up_out));
`default_nettype wire

// [dicd_pkg.sv]
// Purpose: constants for the digital input command decoder
// Assumes: five terminals, six-bit function codes
// Notes:   terminal order is 18, 19, 27, 29, 33 (index 0..4)
package dicd_pkg;
  localparam int NUM_TERM = 5;
  localparam int CODE_W   = 6;
  // function codes
  localparam logic [5:0] FN_NONE         = 6'h00;
  localparam logic [5:0] FN_RESET        = 6'h01;
  localparam logic [5:0] FN_COAST_LOW    = 6'h02;
  localparam logic [5:0] FN_CLEAR_FREE   = 6'h03;
  localparam logic [5:0] FN_QSTOP_LOW    = 6'h04;
  localparam logic [5:0] FN_DCINJ_LOW    = 6'h05;
  localparam logic [5:0] FN_STOP_LOW     = 6'h06;
  localparam logic [5:0] FN_START        = 6'h07;
  localparam logic [5:0] FN_LATCH_START  = 6'h08;
  localparam logic [5:0] FN_REVERSE      = 6'h09;
  localparam logic [5:0] FN_START_REV    = 6'h0a;
  localparam logic [5:0] FN_START_CW     = 6'h0b;
  localparam logic [5:0] FN_START_CCW    = 6'h0c;
  localparam logic [5:0] FN_INCH         = 6'h0d;
  localparam logic [5:0] FN_FREEZE_REF   = 6'h0e;
  localparam logic [5:0] FN_FREEZE_OUT   = 6'h0f;
  localparam logic [5:0] FN_SPEED_UP     = 6'h10;
  localparam logic [5:0] FN_SPEED_DOWN   = 6'h11;
  localparam logic [5:0] FN_ACC_HALT     = 6'h1a;
  localparam logic [5:0] FN_ACC_STARTSTP = 6'h1b;
  localparam logic [5:0] FN_PULSE_REF    = 6'h1c;
  localparam logic [5:0] FN_PULSE_FB     = 6'h1d;
  localparam logic [5:0] FN_PULSE_IN     = 6'h1e;
  localparam logic [5:0] FN_ENC_REF      = 6'h22;
  localparam logic [5:0] FN_ENC_LAST     = 6'h24;
  // defaults after reset, terminals 18/19/27/29/33
  localparam logic [29:0] CODE_RESET_VAL = {6'h00, 6'h0d, 6'h03, 6'h09, 6'h07};
  // timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int PULSE_MIN_MS  = 14;
  localparam int PULSE_MIN_CYC = (CLK_HZ / 1000) * PULSE_MIN_MS;
  localparam int PCNT_W        = 20;
endpackage

// [dicd_term_model.sv]
// Purpose: switches or controller driving the five terminals
// Assumes: terminals are always driven to a full level
// Notes:   changes land just after a clock edge
`timescale 1ns/1ns
`default_nettype none
module dicd_term_model
  import dicd_pkg::*;
(
  // clock
  input  wire logic               clock_in,
  // terminal levels
  output var logic [NUM_TERM-1:0] term_out
);
  // inverse-stop terminal idles high so nothing coasts at start
  initial term_out = 5'h04;
  // change one terminal
  task automatic set(input int idx, input logic lvl);
    @(posedge clock_in);
    #2;
    term_out[idx] = lvl;
  endtask
  // hold a level n cycles; caller picks n below or above the minimum width
  task automatic pulse(input int idx, input logic lvl, input int n);
    set(idx, lvl);
    repeat (n) @(posedge clock_in);
    #2;
    term_out[idx] = !lvl;
  endtask
endmodule
`default_nettype wire

// [digital_input_command_decoder_tb_top.sv]
// Purpose: directed tests of the input command decoder
// Assumes: pulse minimum shortened to 8 cycles
// Notes:   levels checked four cycles after a terminal change
`timescale 1ns/1ns
`default_nettype none
module digital_input_command_decoder_tb_top;
  import dicd_pkg::*;
  localparam int PC = 8;
  // stimulus and results
  logic clock_in = 1'b0, rst_b_in = 1'b0, code_wr_in = 1'b0;
  logic [2:0] code_sel_in = 3'h0;
  logic [5:0] code_val_in = 6'h00;
  logic out_pin_pulse_mode_in = 1'b0, closed_loop_in = 1'b0, alarm_trip_locked_in = 1'b0;
  logic dc_time_nonzero_in = 1'b0, dc_volt_nonzero_in = 1'b0;
  wire logic [4:0] term_in;
  logic [29:0] code_out, exp_code, al0, up0, dn0;
  logic [29:0] al_n = '0, up_n = '0, dn_n = '0;
  logic code_refused_out, alarm_reset_out, coast_out, quick_stop_out, dc_brake_out;
  logic ramp_stop_out, run_out, reverse_out, dir_limit_cw_out, dir_limit_ccw_out;
  logic inch_speed_override_out, freeze_ref_out, freeze_out_out, step_up_out, step_down_out;
  logic [10:0] ent;
  logic [10:0] tbl [10] = '{11'h49a, 11'h01a, 11'h41e, 11'h11e, 11'h422,
                            11'h0e2, 11'h6dc, 11'h0dc, 11'h05b, 11'h492};
  int error_cnt = 0, cmp_count = 0;
  dicd_decoder #(.PULSE_CYC(PC)) i_dicd_decoder (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .term_in(term_in), .code_wr_in(code_wr_in), .code_sel_in(code_sel_in),
    .code_val_in(code_val_in), .out_pin_pulse_mode_in(out_pin_pulse_mode_in),
    .closed_loop_in(closed_loop_in), .dc_time_nonzero_in(dc_time_nonzero_in),
    .dc_volt_nonzero_in(dc_volt_nonzero_in), .alarm_trip_locked_in(alarm_trip_locked_in),
    .code_out(code_out), .code_refused_out(code_refused_out),
    .alarm_reset_out(alarm_reset_out), .coast_out(coast_out), .quick_stop_out(quick_stop_out),
    .dc_brake_out(dc_brake_out), .ramp_stop_out(ramp_stop_out), .run_out(run_out),
    .reverse_out(reverse_out), .dir_limit_cw_out(dir_limit_cw_out),
    .dir_limit_ccw_out(dir_limit_ccw_out), .inch_speed_override_out(inch_speed_override_out),
    .freeze_ref_out(freeze_ref_out), .freeze_out_out(freeze_out_out),
    .step_up_out(step_up_out), .step_down_out(step_down_out));
  dicd_term_model i_dicd_term_model (.clock_in(clock_in), .term_out(term_in));
  // 50 MHz clock
  always #10 clock_in = ~clock_in;
  // pulse counters, read at the falling edge where a one-cycle pulse stands settled
  always @(negedge clock_in) begin
    if (alarm_reset_out === 1'b1) al_n = al_n + 30'h1;
    if (step_up_out === 1'b1) up_n = up_n + 30'h1;
    if (step_down_out === 1'b1) dn_n = dn_n + 30'h1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask
  task automatic st(input int i, input logic v);
    i_dicd_term_model.set(i, v);
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [2:0] sel, input logic [5:0] val);
    cyc(1);
    code_wr_in = 1'b1;
    code_sel_in = sel;
    code_val_in = val;
    cyc(1);
    code_wr_in = 1'b0;
  endtask
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic cmp_word(input logic [29:0] got, input logic [29:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // watchdog, tests need well under 2000 cycles
  initial begin
    #200_000;
    error_cnt++;
    complete_run();
  end
  // main sequence
  initial begin
    exp_code = {6'h00, 6'h0d, 6'h03, 6'h09, 6'h07};
    cyc(2);
    rst_b_in = 1'b1;
    cmp_word(code_out, exp_code, "reset codes");
    for (int i = 0; i < 10; i++) begin
      ent = tbl[i];
      out_pin_pulse_mode_in = ent[9];
      wr(ent[8:6], ent[5:0]);
      if (!ent[10]) exp_code[ent[8:6]*6 +: 6] = ent[5:0];
      cmp_bit(code_refused_out, ent[10], "refusal flag");
      cyc(1); // readback follows the stored code one edge later
      cmp_word(code_out, exp_code, "stored codes");
    end
    out_pin_pulse_mode_in = 1'b0;
    $display("test settings done");
    wr(0, FN_START); wr(1, FN_REVERSE); wr(2, FN_COAST_LOW); wr(3, FN_RESET); wr(4, FN_NONE);
    st(0, 1); cyc(4); cmp_bit(run_out, 1'b1, "start high");
    st(1, 1); cyc(4); cmp_bit(reverse_out, 1'b1, "reverse high");
    st(0, 0); cyc(4); cmp_bit(run_out, 1'b0, "reverse alone");
    closed_loop_in = 1'b1; cyc(4); cmp_bit(reverse_out, 1'b0, "closed loop");
    closed_loop_in = 1'b0; st(1, 0);
    st(2, 0); cyc(4); cmp_bit(coast_out, 1'b1, "coast low");
    st(2, 1); al0 = al_n;
    st(3, 1); cyc(6); cmp_word(al_n - al0, 30'h1, "reset edge");
    st(3, 0); alarm_trip_locked_in = 1'b1; cyc(3); al0 = al_n;
    st(3, 1); cyc(6); cmp_word(al_n - al0, 30'h0, "trip locked");
    alarm_trip_locked_in = 1'b0;
    wr(2, FN_CLEAR_FREE); al0 = al_n;
    st(2, 0); cyc(6); cmp_word(al_n - al0, 30'h1, "falling reset");
    cmp_bit(coast_out, 1'b1, "clear coast");
    st(2, 1); $display("test levels done");
    wr(0, FN_LATCH_START); wr(1, FN_STOP_LOW); wr(2, FN_NONE); st(1, 1);
    i_dicd_term_model.pulse(0, 1, 3); cyc(8); cmp_bit(run_out, 1'b0, "short pulse");
    i_dicd_term_model.pulse(0, 1, PC + 1); cyc(8); cmp_bit(run_out, 1'b1, "latched");
    st(1, 0); cyc(4); cmp_bit(ramp_stop_out, 1'b1, "stop low");
    st(1, 1); cyc(6); cmp_bit(run_out, 1'b0, "latch cleared");
    wr(3, FN_INCH); wr(2, FN_QSTOP_LOW); wr(0, FN_NONE);
    st(3, 1); cyc(4); cmp_bit(inch_speed_override_out, 1'b1, "inch");
    st(2, 0); cyc(4); cmp_bit(quick_stop_out, 1'b1, "quick stop");
    cmp_bit(inch_speed_override_out, 1'b0, "inch blocked");
    st(2, 1); st(3, 0); wr(2, FN_DCINJ_LOW);
    st(2, 0); dc_time_nonzero_in = 1'b1; cyc(4); cmp_bit(dc_brake_out, 1'b0, "dc one set");
    dc_volt_nonzero_in = 1'b1; cyc(4); cmp_bit(dc_brake_out, 1'b1, "dc both set");
    st(2, 1); $display("test stops done");
    // only the first terminal carries a start while these run
    for (int k = 0; k < 3; k++) begin
      wr(0, FN_START_REV + 6'(k));
      st(0, 1); cyc(4);
      cmp_bit(run_out, 1'b1, "dir start run");
      cmp_bit(reverse_out, k != 1, "dir start reverse");
      cmp_bit(dir_limit_cw_out, k == 1, "cw limit");
      cmp_bit(dir_limit_ccw_out, k == 2, "ccw limit");
      st(0, 0); cyc(4);
    end
    wr(0, FN_FREEZE_OUT); wr(4, FN_SPEED_UP); st(0, 1); cyc(PC + 2); up0 = up_n;
    i_dicd_term_model.pulse(4, 1, PC + 2); cyc(6);
    cmp_word(up_n - up0, 30'h1, "one step");
    cmp_bit(freeze_out_out, 1'b1, "freeze output");
    wr(3, FN_SPEED_DOWN); up0 = up_n; dn0 = dn_n;
    i_dicd_term_model.pulse(3, 1, PC + 2); cyc(6);
    cmp_word(dn_n - dn0, 30'h1, "one step down");
    cmp_word(up_n - up0, 30'h0, "no step up on down");
    st(0, 0); cyc(PC + 2); up0 = up_n;
    i_dicd_term_model.pulse(4, 1, PC + 2); cyc(6);
    cmp_word(up_n - up0, 30'h0, "no step unfrozen");
    wr(0, FN_FREEZE_REF); st(0, 1); cyc(4);
    cmp_bit(freeze_ref_out, 1'b1, "freeze reference");
    for (int i = 0; i < 5; i++) wr(3'(i), FN_NONE);
    st(2, 0); st(1, 1); cyc(4);
    cmp_bit(coast_out, 1'b0, "unused coast");
    cmp_bit(reverse_out, 1'b0, "unused reverse");
    $display("test modes done");
    complete_run();
  end
endmodule
`default_nettype wire
